/* File: design/flash_bank_decode_config.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_decode_cfg.svh"
module flash_bank_decode_config (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // ahb slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // configuration from the array controllers
  input wire logic [31:0] i_code_bank_config,
  input wire logic [31:0] i_data_bank_config,
  input wire logic i_cfg_valid,
  // array interface
  output flash_decode_pkg::array_req_type o_array_req,
  output logic [31:0] o_array_wdata,
  input wire logic i_array_ack,
  input wire logic [`PAGE_BITS-1:0] i_array_page,
  // active configuration status
  output flash_decode_pkg::bank_cfg_type o_active_cfg
);
  flash_decode_pkg::region_type region;
  logic addr_bank;
  logic [4:0] emul_wait;

  flash_region_decode u_dec (
    .i_addr(i_haddr),
    .o_region(region),
    .o_bank(addr_bank)
  );

  // configuration shadow; data bank input is not used for timing
  flash_decode_pkg::bank_cfg_type cfg_q;
  flash_decode_pkg::bank_cfg_type cfg_d;
  wire [31:0] cfg_src = i_code_bank_config;
  always_comb begin
    cfg_d.wwsc = cfg_src[`WWSC_LSB +: `WAIT_W];
    cfg_d.read_wait_ctrl = cfg_src[`READ_WAIT_CTRL_LSB +: `WAIT_W];
    cfg_d.addr_pipeline_ctrl = cfg_src[`APC_LSB +: `WAIT_W];
    cfg_d.rwwc = cfg_src[`RWWC_LSB +: `RWWC_W];
  end
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_q.wwsc <= `WWSC_RST;
      cfg_q.read_wait_ctrl <= `READ_WAIT_CTRL_RST;
      cfg_q.addr_pipeline_ctrl <= `APC_RST;
      cfg_q.rwwc <= `RWWC_RST;
    end else if (i_cfg_valid) begin
      cfg_q <= cfg_d;
    end
  end
  assign o_active_cfg = cfg_q;

  // request classification
  wire req_take = i_hsel && i_hready && i_htrans[1];
  wire is_array = region != flash_decode_pkg::rgn_none_type_e &&
    region != flash_decode_pkg::rgn_ccfg &&
    region != flash_decode_pkg::rgn_dcfg;
  wire is_emul = region == flash_decode_pkg::rgn_emul;
  // emulation reads use address-based timing: low address bits add waits
  assign emul_wait = cfg_q.read_wait_ctrl + 5'(i_haddr[`OFFS_BITS +: 2]);
  wire [4:0] wait_load = i_hwrite ? cfg_q.wwsc :
    (is_emul ? emul_wait : cfg_q.read_wait_ctrl);

  flash_decode_pkg::ctl_state_type state_q;
  flash_decode_pkg::ctl_state_type state_d;
  logic [4:0] wait_q;
  logic [4:0] wait_d;
  flash_decode_pkg::array_req_type req_q;
  flash_decode_pkg::array_req_type req_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [`OFFS_BITS-1:0] offs_q;
  logic wr_pend_q;

  wire wait_zero = wait_q == 5'h00;
  wire [1:0] word_sel = offs_q[3:2];
  wire [31:0] page_word = i_array_page[{word_sel, 5'h00} +: 32];

  always_comb begin
    state_d = state_q;
    wait_d = wait_q;
    req_d = req_q;
    rdata_d = rdata_q;
    unique case (state_q)
      flash_decode_pkg::st_idle: begin
        if (req_take && is_array) begin
          state_d = flash_decode_pkg::st_wait;
          wait_d = wait_load;
          req_d.valid = 1'b0;
          req_d.bank = addr_bank;
          req_d.write = i_hwrite;
          req_d.emul = is_emul;
          req_d.addr = i_haddr;
        end else if (req_take) begin
          state_d = flash_decode_pkg::st_err;
        end
      end
      flash_decode_pkg::st_wait: begin
        if (wait_zero) begin
          req_d.valid = 1'b1;
          if (i_array_ack && req_q.valid) begin
            req_d.valid = 1'b0;
            rdata_d = req_q.write ? rdata_q : page_word;
            state_d = flash_decode_pkg::st_done;
          end
        end else begin
          wait_d = wait_q - 5'h01;
        end
      end
      flash_decode_pkg::st_done: state_d = flash_decode_pkg::st_idle;
      flash_decode_pkg::st_err: state_d = flash_decode_pkg::st_idle;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= flash_decode_pkg::st_idle;
      wait_q <= 5'h00;
      req_q <= '0;
      rdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      req_q <= req_d;
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      offs_q <= 4'h0;
      wr_pend_q <= 1'b0;
      o_array_wdata <= 32'h0000_0000;
    end else begin
      if (req_take && state_q == flash_decode_pkg::st_idle) begin
        offs_q <= i_haddr[`OFFS_BITS-1:0];
      end
      wr_pend_q <= req_take && i_hwrite && is_array &&
        state_q == flash_decode_pkg::st_idle;
      if (wr_pend_q) begin
        o_array_wdata <= i_hwdata;
      end
    end
  end

  // ahb answer: wait while busy, two-cycle error for reserved space
  logic err_q;
  wire err_first = state_q == flash_decode_pkg::st_err;
  assign o_hreadyout = !(state_q == flash_decode_pkg::st_wait) &&
    !err_first;
  assign o_hresp = err_first ||
    (state_q == flash_decode_pkg::st_idle && err_q);
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      err_q <= 1'b0;
    end else begin
      err_q <= err_first;
    end
  end
  assign o_hrdata = rdata_q;
  assign o_array_req = req_q;

  // controller register slots, refused on the array port
  wire [31:0] reg_ofs = i_haddr - `CTRL_BASE;
  wire hit_code_cfg = reg_ofs == `OFS_CODE_CFG;
  wire hit_data_cfg = reg_ofs == `OFS_DATA_CFG;
  wire hit_protect = reg_ofs == `OFS_PROTECT;
  wire reg_hit = hit_code_cfg || hit_data_cfg || hit_protect;

  // cycles from the taken address to the array request
  logic [5:0] lat_q;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lat_q <= 6'h00;
    end else if (state_q == flash_decode_pkg::st_idle) begin
      lat_q <= 6'h00;
    end else if (!req_q.valid) begin
      lat_q <= lat_q + 6'h01;
    end
  end

  // checks
  a_bank_follows_a23: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (state_q == flash_decode_pkg::st_idle && req_take && is_array)
    |=> req_q.bank == $past(i_haddr[`BANK_SEL_BIT]))
    else $error("bank select does not follow address bit");
  a_reserved_error: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (state_q == flash_decode_pkg::st_idle && req_take && !is_array)
    |=> (o_hresp && !o_hreadyout && !o_array_req.valid)
    ##1 (o_hresp && o_hreadyout))
    else $error("reserved access lacks two-cycle error");
  a_write_waits: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (state_q == flash_decode_pkg::st_idle && req_take && is_array &&
     i_hwrite && cfg_q.wwsc == `WWSC_RST)
    |=> !o_array_req.valid ##1 !o_array_req.valid ##1 o_array_req.valid)
    else $error("write wait count not honoured");
  a_code_region: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (i_haddr <= `CODE_HI) |-> region == flash_decode_pkg::rgn_code)
    else $error("code array window not decoded");
  a_cfg_from_code: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_cfg_valid |=> cfg_q.read_wait_ctrl ==
      $past(i_code_bank_config[`READ_WAIT_CTRL_LSB +: `WAIT_W]))
    else $error("active timing not from code configuration");
  a_rwwc_reset: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    !$past(i_rst_n) && !$past(i_cfg_valid) |-> cfg_q.rwwc == `RWWC_RST)
    else $error("read-while-write field not at reset value");
  a_cfg_region_no_array: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (state_q == flash_decode_pkg::st_idle && req_take &&
     region == flash_decode_pkg::rgn_ccfg)
    |=> state_q == flash_decode_pkg::st_err)
    else $error("configuration space reached over AHB");
  a_data_bank: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    region == flash_decode_pkg::rgn_data |-> addr_bank)
    else $error("data array window not on second bank");
  c_read_done: cover property (@(posedge i_core_clk)
    state_q == flash_decode_pkg::st_done && !req_q.write);
  c_write_done: cover property (@(posedge i_core_clk)
    state_q == flash_decode_pkg::st_done && req_q.write);
  c_error: cover property (@(posedge i_core_clk) err_first);

  a_shadow_region: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (i_haddr >= `SHADOW_LO && i_haddr <= `SHADOW_HI)
    |-> region == flash_decode_pkg::rgn_shadow)
    else $error("shadow sector window not decoded");

  a_ctest_region: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (i_haddr >= `CTEST_LO && i_haddr <= `CTEST_HI)
    |-> region == flash_decode_pkg::rgn_ctest)
    else $error("code test sector window not decoded");

  a_dtest_region: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (i_haddr >= `DTEST_LO && i_haddr <= `DTEST_HI)
    |-> region == flash_decode_pkg::rgn_dtest)
    else $error("data test sector window not decoded");

  a_ccfg_region: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (i_haddr >= `CCFG_LO && i_haddr <= `CCFG_HI)
    |-> region == flash_decode_pkg::rgn_ccfg)
    else $error("code configuration window not decoded");

  a_dcfg_region: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (i_haddr >= `DCFG_LO && i_haddr <= `DCFG_HI)
    |-> region == flash_decode_pkg::rgn_dcfg)
    else $error("data configuration window not decoded");

  a_data_req: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (state_q == flash_decode_pkg::st_idle && req_take &&
     region == flash_decode_pkg::rgn_data)
    |=> req_q.bank && !req_q.emul)
    else $error("data array access not on second bank");

  a_emul_flag: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (state_q == flash_decode_pkg::st_idle && req_take &&
     i_haddr >= `EMUL_LO && i_haddr <= `EMUL_HI)
    |=> req_q.emul && state_q == flash_decode_pkg::st_wait)
    else $error("emulation access not marked");

  a_request_holds: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    req_q.valid && !i_array_ack |=> req_q.valid)
    else $error("array request dropped before acknowledge");

  a_read_word: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (req_q.valid && i_array_ack && !req_q.write)
    |=> o_hrdata ==
      $past(i_array_page[{req_q.addr[`OFFS_BITS-1 -: 2], 5'h00} +: 32]))
    else $error("read word not taken from page");

  a_error_no_array: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    err_first |-> !req_q.valid)
    else $error("array request during error answer");

  a_idle_ready: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (state_q == flash_decode_pkg::st_idle && !err_q)
    |-> o_hreadyout && !o_hresp)
    else $error("idle answer not ready and okay");

  a_wwsc_reset: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    !$past(i_rst_n) && !$past(i_cfg_valid) |-> cfg_q.wwsc == `WWSC_RST)
    else $error("write wait field not at reset value");

  a_cfg_fields: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_cfg_valid |=>
      cfg_q.wwsc == $past(i_code_bank_config[`WWSC_LSB +: `WAIT_W]) &&
      cfg_q.addr_pipeline_ctrl == $past(i_code_bank_config[`APC_LSB +: `WAIT_W]) &&
      cfg_q.rwwc == $past(i_code_bank_config[`RWWC_LSB +: `RWWC_W]))
    else $error("active fields not from their positions");

  a_cfg_hold: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    !i_cfg_valid |=> $stable(cfg_q))
    else $error("configuration changed without valid");

  a_reg_refused: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (state_q == flash_decode_pkg::st_idle && req_take && reg_hit)
    |=> err_first)
    else $error("controller register reached over AHB");

  a_write_latency: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(req_q.valid) && req_q.write
    |-> lat_q == 6'(cfg_q.wwsc) + 6'h01)
    else $error("write request not after write wait count");

  a_read_latency: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(req_q.valid) && !req_q.write && !req_q.emul
    |-> lat_q == 6'(cfg_q.read_wait_ctrl) + 6'h01)
    else $error("read request not after read wait count");

  a_emul_latency: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(req_q.valid) && !req_q.write && req_q.emul
    |-> lat_q ==
      {1'b0, 5'(cfg_q.read_wait_ctrl + 5'(req_q.addr[`OFFS_BITS +: 2]))} + 6'h01)
    else $error("emulation read not after address based wait");

  c_emul_read: cover property (@(posedge i_core_clk)
    state_q == flash_decode_pkg::st_done && req_q.emul);
  c_cfg_load: cover property (@(posedge i_core_clk)
    i_cfg_valid && cfg_q.read_wait_ctrl != `READ_WAIT_CTRL_RST);
endmodule : flash_bank_decode_config
`default_nettype wire

/* File: design/flash_decode_cfg.svh */
`ifndef FLASH_DECODE_CFG_SVH
`define FLASH_DECODE_CFG_SVH
// Contract
// - address bit 23 selects code or data bank
// - array via AHB, configuration via peripheral bus
// - code array at 0x0 to 0x7FFFF
// - code shadow sector window decoded
// - code test sector window decoded
// - data array window selects second bank
// - data test sector window decoded
// - emulation window uses address-based read timing
// - code configuration peripheral window decoded
// - data configuration peripheral window decoded
// - no registers inside; configuration arrives as inputs
// - code array configuration governs both banks
// - register set based at peripheral base
// - config0, config1, protection at consecutive words
// - second port fields have no effect
// - write wait count adds write wait states
// - reset loads usable write wait value
// - array read returns 128-bit page
// - reset sets read-while-write field to stall
`define CODE_LO 32'h0000_0000
`define CODE_HI 32'h0007_FFFF
`define SHADOW_LO 32'h0020_0000
`define SHADOW_HI 32'h0027_FFFF
`define CTEST_LO 32'h0040_0000
`define CTEST_HI 32'h0040_3FFF
`define DATA_LO 32'h0080_0000
`define DATA_HI 32'h0080_FFFF
`define DTEST_LO 32'h00C0_0000
`define DTEST_HI 32'h00C7_FFFF
`define EMUL_LO 32'h0100_0000
`define EMUL_HI 32'h1FFF_FFFF
`define CCFG_LO 32'hC3F8_8000
`define CCFG_HI 32'hC3F8_BFFF
`define DCFG_LO 32'hC3F8_C000
`define DCFG_HI 32'hC3F8_FFFF
`define CTRL_BASE 32'hC3F8_8000
`define OFS_CODE_CFG 32'h0000_001C
`define OFS_DATA_CFG 32'h0000_0020
`define OFS_PROTECT 32'h0000_0024
`define BANK_SEL_BIT 23
`define WWSC_LSB 5
`define READ_WAIT_CTRL_LSB 10
`define APC_LSB 15
`define RWWC_LSB 20
`define WAIT_W 5
`define RWWC_W 3
`define WWSC_RST 5'h01
`define READ_WAIT_CTRL_RST 5'h02
`define APC_RST 5'h02
`define RWWC_RST 3'h7
`define PAGE_BITS 128
`define OFFS_BITS 4
`endif

/* File: design/flash_decode_pkg.sv */
package flash_decode_pkg;
  typedef enum logic [3:0] {
    rgn_none_type_e = 4'h0,
    rgn_code = 4'h1,
    rgn_shadow = 4'h2,
    rgn_ctest = 4'h3,
    rgn_data = 4'h4,
    rgn_dtest = 4'h5,
    rgn_emul = 4'h6,
    rgn_ccfg = 4'h7,
    rgn_dcfg = 4'h8
  } region_type;

  typedef struct packed {
    logic [2:0] rwwc;
    logic [4:0] addr_pipeline_ctrl;
    logic [4:0] read_wait_ctrl;
    logic [4:0] wwsc;
  } bank_cfg_type;

  typedef struct packed {
    logic valid;
    logic bank;
    logic write;
    logic emul;
    logic [31:0] addr;
  } array_req_type;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_wait = 2'b01,
    st_done = 2'b11,
    st_err = 2'b10
  } ctl_state_type;
endpackage : flash_decode_pkg

/* File: design/flash_region_decode.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_decode_cfg.svh"
module flash_region_decode (
  // address in
  input wire logic [31:0] i_addr,
  // region out
  output flash_decode_pkg::region_type o_region,
  output logic o_bank
);
  wire in_code = i_addr <= `CODE_HI;
  wire in_shadow = i_addr >= `SHADOW_LO && i_addr <= `SHADOW_HI;
  wire in_ctest = i_addr >= `CTEST_LO && i_addr <= `CTEST_HI;
  wire in_data = i_addr >= `DATA_LO && i_addr <= `DATA_HI;
  wire in_dtest = i_addr >= `DTEST_LO && i_addr <= `DTEST_HI;
  wire in_emul = i_addr >= `EMUL_LO && i_addr <= `EMUL_HI;
  wire in_ccfg = i_addr >= `CCFG_LO && i_addr <= `CCFG_HI;
  wire in_dcfg = i_addr >= `DCFG_LO && i_addr <= `DCFG_HI;

  assign o_bank = i_addr[`BANK_SEL_BIT];
  assign o_region =
    in_code ? flash_decode_pkg::rgn_code :
    in_shadow ? flash_decode_pkg::rgn_shadow :
    in_ctest ? flash_decode_pkg::rgn_ctest :
    in_data ? flash_decode_pkg::rgn_data :
    in_dtest ? flash_decode_pkg::rgn_dtest :
    in_emul ? flash_decode_pkg::rgn_emul :
    in_ccfg ? flash_decode_pkg::rgn_ccfg :
    in_dcfg ? flash_decode_pkg::rgn_dcfg :
    flash_decode_pkg::rgn_none_type_e;
endmodule : flash_region_decode
`default_nettype wire

/* File: sim/flash_array_model.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // request side
  input wire flash_decode_pkg::array_req_type i_req,
  input wire logic [3:0] i_delay,
  // answer side
  output logic o_ack,
  output logic [127:0] o_page,
  output var int o_count
);
  logic [3:0] cnt_q;
  // page words follow the word address, inverted while not acking
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      o_page[32*k +: 32] = {i_req.addr[31:4], 2'(k), 2'b00}
        ^ 32'h5A5A_0F0F ^ {32{~o_ack}};
    end
  end
  // one-cycle ack after a chosen number of idle cycles
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 4'h0;
      o_ack <= 1'b0;
      o_count <= 0;
    end else if (o_ack) begin
      o_ack <= 1'b0;
      cnt_q <= 4'h0;
    end else if (i_req.valid && cnt_q >= i_delay) begin
      o_ack <= 1'b1;
      o_count <= o_count + 1;
    end else if (i_req.valid) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : flash_array_model
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_decode_cfg.svh"
module testbench;
  logic clk, rst_n, hsel, hwrite, cfg_valid, ack, rdy, hresp, rsp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, code_cfg, data_cfg, wdata, rd, wd_seen;
  logic [3:0] dly;
  logic [127:0] page;
  flash_decode_pkg::array_req_type req, seen;
  flash_decode_pkg::bank_cfg_type act;
  int n_errors = 0, n_compared = 0, cyc = 0, cnt, c0, l0, l1, w0, w1;
  logic [31:0] ok_a [8] = '{32'h0000_0000, 32'h0007_FFFC, 32'h0027_FFF8,
    32'h0040_3FF4, 32'h0080_0000, 32'h0080_FFFC, 32'h00C7_FFF0,
    32'h1FFF_FFFC};
  logic [31:0] err_a [9] = '{32'h0008_0000, 32'h001F_FFFC, 32'h0040_4000,
    32'h0081_0000, 32'h00C8_0000, 32'h2000_0000, 32'hC3F8_801C,
    32'hC3F8_C020, 32'hC3F8_8024};

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  flash_bank_decode_config u_dut (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hwdata(hwdata), .i_hready(rdy), .o_hreadyout(rdy), .o_hresp(hresp),
    .o_hrdata(hrdata), .i_code_bank_config(code_cfg),
    .i_data_bank_config(data_cfg), .i_cfg_valid(cfg_valid),
    .o_array_req(req), .o_array_wdata(wdata), .i_array_ack(ack),
    .i_array_page(page), .o_active_cfg(act));

  flash_array_model u_array (.i_core_clk(clk), .i_rst_n(rst_n), .i_req(req),
    .i_delay(dly), .o_ack(ack), .o_page(page), .o_count(cnt));

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] sv, input logic [31:0] ev);
    n_compared++;
    if (sv !== ev) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, sv, ev);
    end
  endtask : check

  // one AHB transfer; lat is the sample at which the array request shows
  task automatic ahb(input logic [31:0] a, input logic w,
    input logic [31:0] wd, output logic rsp_o, output int lat);
    int n;
    n = 0;
    lat = 0;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(negedge clk);
      n++;
      if (req.valid === 1'b1 && lat == 0) begin
        lat = n;
        seen = req;
        wd_seen = wdata;
      end
    end while (rdy !== 1'b1 && n < 300);
    if (rdy !== 1'b1) n_errors++;
    rd = hrdata;
    rsp_o = hresp;
  endtask : ahb

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end

  initial begin
    {rst_n, hsel, hwrite, cfg_valid, htrans, dly} = '0;
    {haddr, hwdata, code_cfg, data_cfg} = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check(32'(act), 32'({3'h7, 5'h02, 5'h02, 5'h01}));
    check({rdy, hresp}, 32'h2);
    $display("reset test done");
    foreach (ok_a[i]) begin
      ahb(ok_a[i], 1'b0, 32'h0, rsp, l0);
      check(rsp, 32'h0);
      check(seen.bank, ok_a[i][23]);
      check(seen.emul, 32'(ok_a[i] >= 32'h0100_0000));
      check(rd, {ok_a[i][31:2], 2'b00} ^ 32'h5A5A_0F0F);
    end
    $display("region test done");
    foreach (err_a[i]) begin
      c0 = cnt;
      ahb(err_a[i], 1'b0, 32'h0, rsp, l0);
      check(rsp, 32'h1);
      check(32'(cnt), 32'(c0));
    end
    $display("error test done");
    ahb(32'h0000_0040, 1'b0, 32'h0, rsp, l0);
    ahb(32'h0000_0080, 1'b1, 32'hC0DE_1234, rsp, w0);
    check(seen.write, 32'h1);
    check(wd_seen, 32'hC0DE_1234);
    @(posedge clk);
    code_cfg <= (32'h5 << `RWWC_LSB) | (32'h5 << `APC_LSB)
      | (32'h5 << `READ_WAIT_CTRL_LSB) | (32'h4 << `WWSC_LSB) | 32'hFF80_001F;
    data_cfg <= 32'hFFFF_FFFF;
    cfg_valid <= 1'b1;
    repeat (2) @(negedge clk);
    check(32'(act), 32'({3'h5, 5'h05, 5'h05, 5'h04}));
    ahb(32'h0000_0040, 1'b0, 32'h0, rsp, l1);
    check(32'(l1 - l0), 32'h3);
    ahb(32'h0080_0040, 1'b0, 32'h0, rsp, l0);
    check(32'(l0), 32'(l1));
    ahb(32'h0000_0080, 1'b1, 32'h0BAD_F00D, rsp, w1);
    check(32'(w1 - w0), 32'h3);
    ahb(32'h0100_0000, 1'b0, 32'h0, rsp, l0);
    ahb(32'h0100_0030, 1'b0, 32'h0, rsp, l1);
    check(32'(l1 - l0), 32'h3);
    $display("timing test done");
    @(posedge clk);
    data_cfg <= code_cfg;
    dly <= 4'h5;
    ahb(32'h0080_0018, 1'b0, 32'h0, rsp, l0);
    check(rd, 32'h0080_0018 ^ 32'h5A5A_0F0F);
    $display("slow array test done");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
